/* File: hw/ccd_params.svh */
`ifndef CCD_PARAMS_SVH
`define CCD_PARAMS_SVH

// Register addresses
`define CCD_A_D0_CNT 9'h190
`define CCD_A_D0_CTL 9'h191
`define CCD_A_C0_RTE 9'h192
`define CCD_A_D1_CNT 9'h193
`define CCD_A_D1_CTL 9'h194
`define CCD_A_C1_RTE 9'h195

// Cycle-count register fields
`define CCD_LOW_HI 7
`define CCD_LOW_LO 4
`define CCD_HIGH_HI 3
`define CCD_HIGH_LO 0

// Divider control register fields
`define CCD_BIT_BYPASS 7
`define CCD_BIT_IGN_SYNC 6
`define CCD_BIT_FORCE 5
`define CCD_BIT_START_HIGH 4
`define CCD_PHASE_HI 3
`define CCD_PHASE_LO 0

// Channel routing and power register fields
`define CCD_BIT_PWR_DOWN 2
`define CCD_BIT_DIRECT 1
`define CCD_BIT_DCC_DIS 0
`define CCD_RTE_MASK 8'h07

// Reset values
`define CCD_RST_D0_CNT 8'h77
`define CCD_RST_D1_CNT 8'h33
`define CCD_RST_CTL 8'h00
`define CCD_RST_RTE 8'h00
`define CCD_RD_UNMAPPED 8'h00

`endif

/* File: hw/ccd_pkg.sv */
package ccd_pkg;
    typedef enum logic {ST_RUN, ST_DELAY} ccd_div_state_t;
    typedef logic [7:0] ccd_reg_t;
endpackage

/* File: hw/ccd_divider.sv */
`timescale 1ns/10ps
module ccd_divider (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Settings
    input wire logic [3:0] low_cnt_i,
    input wire logic [3:0] high_cnt_i,
    input wire logic [3:0] phase_i,
    input wire logic bypass_i,
    input wire logic ignore_sync_i,
    input wire logic force_i,
    input wire logic start_high_i,
    // Alignment and output
    input wire logic sync_i,
    output logic div_o
);

ccd_pkg::ccd_div_state_t state_q;
ccd_pkg::ccd_div_state_t state_d;
logic [3:0] cnt_q;
logic [3:0] cnt_d;
logic div_q;
logic div_d;
logic [3:0] len;

assign len = div_q ? high_cnt_i : low_cnt_i;
assign div_o = div_q;

////////////////////////////////////////////////////////////////////////
always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    div_d = div_q;
    if (bypass_i) begin
        // Counter held idle; output follows the input rate.
        state_d = ccd_pkg::ST_RUN;
        cnt_d = 4'h0;
        div_d = ~div_q;
    end else if (ignore_sync_i && force_i) begin
        // Static level only while alignment is ignored.
        state_d = ccd_pkg::ST_RUN;
        cnt_d = 4'h0;
        div_d = start_high_i;
    end else if (sync_i && !ignore_sync_i) begin
        // Restart at start level at once; counting resumes after the phase offset.
        div_d = start_high_i;
        cnt_d = phase_i;
        state_d = (phase_i == 4'h0) ? ccd_pkg::ST_RUN : ccd_pkg::ST_DELAY;
    end else begin
        unique case (state_q)
            ccd_pkg::ST_DELAY: begin
                if (cnt_q == 4'h1) begin
                    state_d = ccd_pkg::ST_RUN;
                    cnt_d = 4'h0;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            ccd_pkg::ST_RUN: begin
                // Greater-or-equal so a shortened count cannot stall.
                if (cnt_q >= len) begin
                    div_d = ~div_q;
                    cnt_d = 4'h0;
                end else begin
                    cnt_d = cnt_q + 4'h1;
                end
            end
        endcase
    end
end

always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        state_q <= ccd_pkg::ST_RUN;
        cnt_q <= 4'h0;
        div_q <= 1'b0;
    end else begin
        state_q <= state_d;
        cnt_q <= cnt_d;
        div_q <= div_d;
    end
end

////////////////////////////////////////////////////////////////////////
logic normal;
assign normal = !bypass_i && !(ignore_sync_i && force_i)
    && !(sync_i && !ignore_sync_i);

property p_bypass_toggle;
    @(posedge clk_i) disable iff (!rst_b_i)
    bypass_i |=> (div_q != $past(div_q)) && (cnt_q == 4'h0);
endproperty
a_bypass_toggle: assert property (p_bypass_toggle)
    else $error("bypass did not pass the input rate");

property p_force_level;
    @(posedge clk_i) disable iff (!rst_b_i)
    !bypass_i && ignore_sync_i && force_i |=> div_q == $past(start_high_i);
endproperty
a_force_level: assert property (p_force_level)
    else $error("forced level wrong");

property p_sync_restart;
    @(posedge clk_i) disable iff (!rst_b_i)
    !bypass_i && sync_i && !ignore_sync_i
        |=> div_q == $past(start_high_i) && cnt_q == $past(phase_i);
endproperty
a_sync_restart: assert property (p_sync_restart)
    else $error("alignment restart wrong");

property p_sync_ignored;
    @(posedge clk_i) disable iff (!rst_b_i)
    !bypass_i && ignore_sync_i && !force_i && sync_i
        && state_q == ccd_pkg::ST_RUN && cnt_q < len
        |=> div_q == $past(div_q) && cnt_q == $past(cnt_q) + 4'h1;
endproperty
a_sync_ignored: assert property (p_sync_ignored)
    else $error("ignored alignment disturbed divider");

property p_toggle_at_end;
    @(posedge clk_i) disable iff (!rst_b_i)
    normal && state_q == ccd_pkg::ST_RUN && cnt_q == len
        |=> div_q != $past(div_q) && cnt_q == 4'h0;
endproperty
a_toggle_at_end: assert property (p_toggle_at_end)
    else $error("no toggle at count boundary");

property p_hold_low;
    @(posedge clk_i) disable iff (!rst_b_i)
    normal && state_q == ccd_pkg::ST_RUN && !div_q && cnt_q < low_cnt_i
        |=> !div_q;
endproperty
a_hold_low: assert property (p_hold_low)
    else $error("low phase too short");

property p_hold_high;
    @(posedge clk_i) disable iff (!rst_b_i)
    normal && state_q == ccd_pkg::ST_RUN && div_q && cnt_q < high_cnt_i
        |=> div_q;
endproperty
a_hold_high: assert property (p_hold_high)
    else $error("high phase too short");

property p_delay_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
    normal && state_q == ccd_pkg::ST_DELAY
        |=> div_q == $past(div_q);
endproperty
a_delay_hold: assert property (p_delay_hold)
    else $error("output moved during phase delay");

endmodule

/* File: hw/ccd_channel.sv */
`timescale 1ns/10ps
module ccd_channel (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Routing settings
    input wire logic pwr_down_i,
    input wire logic direct_i,
    input wire logic route_block_i,
    input wire logic dcc_dis_i,
    // Clock sources
    input wire logic div_i,
    input wire logic clk_tog_i,
    // Group outputs
    output logic ch_clk_o,
    output logic ch_pd_o,
    output logic ch_dcc_en_o
);

logic clk_q;
logic clk_d;
logic pd_q;
logic pd_d;
logic dcc_q;
logic dcc_d;

always_comb begin
    pd_d = pwr_down_i;
    dcc_d = !dcc_dis_i;
    if (pwr_down_i) begin
        clk_d = 1'b0;
    end else if (direct_i && !route_block_i) begin
        clk_d = clk_tog_i;
    end else begin
        clk_d = div_i;
    end
end

always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        clk_q <= 1'b0;
        pd_q <= 1'b0;
        dcc_q <= 1'b1;
    end else begin
        clk_q <= clk_d;
        pd_q <= pd_d;
        dcc_q <= dcc_d;
    end
end

assign ch_clk_o = clk_q;
assign ch_pd_o = pd_q;
assign ch_dcc_en_o = dcc_q;

////////////////////////////////////////////////////////////////////////
property p_pd;
    @(posedge clk_i) disable iff (!rst_b_i)
    pwr_down_i |=> !ch_clk_o && ch_pd_o;
endproperty
a_pd: assert property (p_pd)
    else $error("powered-down group still active");

property p_direct;
    @(posedge clk_i) disable iff (!rst_b_i)
    !pwr_down_i && direct_i && !route_block_i
        |=> ch_clk_o == $past(clk_tog_i);
endproperty
a_direct: assert property (p_direct)
    else $error("direct clock not routed");

property p_route_block;
    @(posedge clk_i) disable iff (!rst_b_i)
    !pwr_down_i && (!direct_i || route_block_i)
        |=> ch_clk_o == $past(div_i);
endproperty
a_route_block: assert property (p_route_block)
    else $error("divider not routed");

property p_dcc;
    @(posedge clk_i) disable iff (!rst_b_i)
    $changed(dcc_dis_i) |=> ch_dcc_en_o != $past(dcc_dis_i);
endproperty
a_dcc: assert property (p_dcc)
    else $error("duty-cycle correction enable wrong");

endmodule

/* File: hw/ccd_top.sv */
// Overview of operation
// - Divider output stays low for low-cycle field [7:4] plus one cycles.
// - Divider output stays high for high-cycle field [3:0] plus one cycles.
// - After reset divider 0 counts are 7 and 7, divider 1 are 3.
// - Bypass idles the counter and passes the input clock to the output.
// - Ignore-sync clear obeys the alignment signal; set disregards it.
// - Force drives a static level, low or start-high, only with ignore-sync.
// - Force has no effect while bypassed; driver inversion stays usable.
// - Start-high picks the level the divided clock begins at; reset is low.
// - A four-bit phase offset in bits 3..0 shifts the output; resets zero.
// - Channel power-down puts all three group outputs into safe power-down.
// - Direct-to-output feeds the undivided clock unless routing blocks it.
// - Duty-cycle correction is on unless its disable bit is set.
// - The second group's controls act on its outputs like the first's.
`timescale 1ns/10ps
`include "ccd_params.svh"

module ccd_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,

    // Register port
    input wire logic [8:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,

    // Chip-level alignment and global routing
    input wire logic sync_i,
    input wire logic route_block_i,

    // Channel group outputs
    output logic [1:0] ch_clk_o,
    output logic [1:0] ch_pd_o,
    output logic [1:0] ch_dcc_en_o
);

////////////////////////////////////////////////////////////////////////
// Register storage

ccd_pkg::ccd_reg_t cnt_q [2];
ccd_pkg::ccd_reg_t cnt_d [2];
ccd_pkg::ccd_reg_t ctl_q [2];
ccd_pkg::ccd_reg_t ctl_d [2];
ccd_pkg::ccd_reg_t rte_q [2];
ccd_pkg::ccd_reg_t rte_d [2];
ccd_pkg::ccd_reg_t rdata_q;
ccd_pkg::ccd_reg_t rdata_d;
logic after_rst_q;
logic after_rst_d;
logic clk_tog_q;
logic clk_tog_d;

always_comb begin
    for (int i = 0; i < 2; i++) begin
        cnt_d[i] = cnt_q[i];
        ctl_d[i] = ctl_q[i];
        rte_d[i] = rte_q[i];
    end
    // Writes to unmapped addresses are dropped silently
    if (reg_wr_i) begin
        case (reg_addr_i)
            `CCD_A_D0_CNT: begin
                cnt_d[0] = reg_wdata_i;
            end
            `CCD_A_D0_CTL: begin
                ctl_d[0] = reg_wdata_i;
            end
            `CCD_A_C0_RTE: begin
                rte_d[0] = reg_wdata_i & `CCD_RTE_MASK;
            end
            `CCD_A_D1_CNT: begin
                cnt_d[1] = reg_wdata_i;
            end
            `CCD_A_D1_CTL: begin
                ctl_d[1] = reg_wdata_i;
            end
            `CCD_A_C1_RTE: begin
                rte_d[1] = reg_wdata_i & `CCD_RTE_MASK;
            end
            default: begin
            end
        endcase
    end
end

always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        cnt_q[0] <= `CCD_RST_D0_CNT;
        cnt_q[1] <= `CCD_RST_D1_CNT;
        ctl_q[0] <= `CCD_RST_CTL;
        ctl_q[1] <= `CCD_RST_CTL;
        rte_q[0] <= `CCD_RST_RTE;
        rte_q[1] <= `CCD_RST_RTE;
    end else begin
        for (int i = 0; i < 2; i++) begin
            cnt_q[i] <= cnt_d[i];
            ctl_q[i] <= ctl_d[i];
            rte_q[i] <= rte_d[i];
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Read-back, one cycle after the read strobe; held between reads

always_comb begin
    rdata_d = rdata_q;
    if (reg_rd_i) begin
        case (reg_addr_i)
            `CCD_A_D0_CNT: begin
                rdata_d = cnt_q[0];
            end
            `CCD_A_D0_CTL: begin
                rdata_d = ctl_q[0];
            end
            `CCD_A_C0_RTE: begin
                rdata_d = rte_q[0];
            end
            `CCD_A_D1_CNT: begin
                rdata_d = cnt_q[1];
            end
            `CCD_A_D1_CTL: begin
                rdata_d = ctl_q[1];
            end
            `CCD_A_C1_RTE: begin
                rdata_d = rte_q[1];
            end
            default: begin
                rdata_d = `CCD_RD_UNMAPPED;
            end
        endcase
    end
end

always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        rdata_q <= `CCD_RD_UNMAPPED;
    end else begin
        rdata_q <= rdata_d;
    end
end

assign reg_rdata_o = rdata_q;

////////////////////////////////////////////////////////////////////////
// Undivided clock as seen at this clock rate, and post-reset marker

always_comb begin
    // A toggle each cycle stands in for the raw input clock
    clk_tog_d = ~clk_tog_q;
    after_rst_d = 1'b1;
end

always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        clk_tog_q <= 1'b0;
        after_rst_q <= 1'b0;
    end else begin
        clk_tog_q <= clk_tog_d;
        after_rst_q <= after_rst_d;
    end
end

////////////////////////////////////////////////////////////////////////
// Two identical divider and routing slices

logic [1:0] div_w;

for (genvar g = 0; g < 2; g++) begin : g_ch
    // Slice 1 mirrors slice 0 exactly, on its own registers.
    ccd_divider u_div (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .low_cnt_i(cnt_q[g][`CCD_LOW_HI:`CCD_LOW_LO]),
        .high_cnt_i(cnt_q[g][`CCD_HIGH_HI:`CCD_HIGH_LO]),
        .phase_i(ctl_q[g][`CCD_PHASE_HI:`CCD_PHASE_LO]),
        .bypass_i(ctl_q[g][`CCD_BIT_BYPASS]),
        .ignore_sync_i(ctl_q[g][`CCD_BIT_IGN_SYNC]),
        .force_i(ctl_q[g][`CCD_BIT_FORCE]),
        .start_high_i(ctl_q[g][`CCD_BIT_START_HIGH]),
        .sync_i(sync_i),
        .div_o(div_w[g])
    );

    ccd_channel u_ch (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .pwr_down_i(rte_q[g][`CCD_BIT_PWR_DOWN]),
        .direct_i(rte_q[g][`CCD_BIT_DIRECT]),
        .route_block_i(route_block_i),
        .dcc_dis_i(rte_q[g][`CCD_BIT_DCC_DIS]),
        .div_i(div_w[g]),
        .clk_tog_i(clk_tog_q),
        .ch_clk_o(ch_clk_o[g]),
        .ch_pd_o(ch_pd_o[g]),
        .ch_dcc_en_o(ch_dcc_en_o[g])
    );
end

////////////////////////////////////////////////////////////////////////
// Checks on the register file and the group outputs

property p_reset_counts;
    @(posedge clk_i) disable iff (!rst_b_i)
    !after_rst_q |-> cnt_q[0] == `CCD_RST_D0_CNT
        && cnt_q[1] == `CCD_RST_D1_CNT
        && ctl_q[0] == `CCD_RST_CTL && ctl_q[1] == `CCD_RST_CTL
        && rte_q[0] == `CCD_RST_RTE && rte_q[1] == `CCD_RST_RTE;
endproperty
a_reset_counts: assert property (p_reset_counts)
    else $error("reset values wrong");

property p_readback_rte;
    @(posedge clk_i) disable iff (!rst_b_i)
    reg_rd_i && reg_addr_i == `CCD_A_C0_RTE |=> reg_rdata_o[7:3] == 5'h00;
endproperty
a_readback_rte: assert property (p_readback_rte)
    else $error("unused routing bits not zero");

property p_write_then_read;
    @(posedge clk_i) disable iff (!rst_b_i)
    reg_wr_i && reg_addr_i == `CCD_A_D1_CNT ##1 reg_rd_i && !reg_wr_i
        && reg_addr_i == `CCD_A_D1_CNT
        |=> reg_rdata_o == $past(reg_wdata_i, 2);
endproperty
a_write_then_read: assert property (p_write_then_read)
    else $error("divider 1 counts not stored");

property p_pd_group1;
    @(posedge clk_i) disable iff (!rst_b_i)
    rte_q[1][`CCD_BIT_PWR_DOWN] |=> ch_pd_o[1] && !ch_clk_o[1];
endproperty
a_pd_group1: assert property (p_pd_group1)
    else $error("group 1 power-down ignored");

property p_start_low_default;
    @(posedge clk_i) disable iff (!rst_b_i)
    !after_rst_q |-> ch_clk_o == 2'b00 && ch_dcc_en_o == 2'b11;
endproperty
a_start_low_default: assert property (p_start_low_default)
    else $error("outputs not at default after reset");

// Read data stands until the next read strobe
property p_rdata_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
    !reg_rd_i |=> $stable(reg_rdata_o);
endproperty
a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");

property p_read_unmapped;
    @(posedge clk_i) disable iff (!rst_b_i)
    reg_rd_i && (reg_addr_i < `CCD_A_D0_CNT || reg_addr_i > `CCD_A_C1_RTE)
        |=> reg_rdata_o == `CCD_RD_UNMAPPED;
endproperty
a_read_unmapped: assert property (p_read_unmapped)
    else $error("unmapped read not zero");

property p_readback_rte1;
    @(posedge clk_i) disable iff (!rst_b_i)
    reg_rd_i && reg_addr_i == `CCD_A_C1_RTE |=> reg_rdata_o[7:3] == 5'h00;
endproperty
a_readback_rte1: assert property (p_readback_rte1)
    else $error("unused group 1 routing bits not zero");

property p_write_ctl0;
    @(posedge clk_i) disable iff (!rst_b_i)
    reg_wr_i && reg_addr_i == `CCD_A_D0_CTL |=> ctl_q[0] == $past(reg_wdata_i);
endproperty
a_write_ctl0: assert property (p_write_ctl0)
    else $error("divider 0 control not stored");

property p_write_rte1;
    @(posedge clk_i) disable iff (!rst_b_i)
    reg_wr_i && reg_addr_i == `CCD_A_C1_RTE
        |=> rte_q[1] == ($past(reg_wdata_i) & `CCD_RTE_MASK);
endproperty
a_write_rte1: assert property (p_write_rte1)
    else $error("group 1 routing not stored");

property p_pd_group0;
    @(posedge clk_i) disable iff (!rst_b_i)
    rte_q[0][`CCD_BIT_PWR_DOWN] |=> ch_pd_o[0] && !ch_clk_o[0];
endproperty
a_pd_group0: assert property (p_pd_group0)
    else $error("group 0 power-down ignored");

property p_dcc_group1;
    @(posedge clk_i) disable iff (!rst_b_i)
    rte_q[1][`CCD_BIT_DCC_DIS] |=> !ch_dcc_en_o[1];
endproperty
a_dcc_group1: assert property (p_dcc_group1)
    else $error("group 1 duty-cycle correction not disabled");

c_bypass0: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    ctl_q[0][7] && ch_clk_o[0]);
c_sync_delay: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    sync_i && ctl_q[1][3:0] != 4'h0 && !ctl_q[1][6]);
c_direct1: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    rte_q[1][1] && !route_block_i && ch_clk_o[1]);
c_force_high: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    ctl_q[0][6:4] == 3'b111 && ch_clk_o[0]);
c_blocked1: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    rte_q[1][`CCD_BIT_DIRECT] && route_block_i);

endmodule

/* File: tb/ccd_drv_model.sv */
`timescale 1ns/10ps
module ccd_drv_model (
    // From the channel group
    input wire logic ch_clk_i,
    input wire logic ch_pd_i,
    input wire logic invert_i,
    // Three driven outputs of the group
    output logic [2:0] out_o
);
    // Powered-down drivers sit at a fixed safe low, whatever the polarity
    always_comb begin
        out_o = ch_pd_i ? 3'h0 : {3{ch_clk_i ^ invert_i}};
    end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`include "ccd_params.svh"
module testbench;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [8:0] reg_addr_i = 9'h000;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic sync_i = 1'b0;
    logic route_block_i = 1'b0;
    logic invert_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic [1:0] ch_clk_o;
    logic [1:0] ch_pd_o;
    logic [1:0] ch_dcc_en_o;
    logic [2:0] drv_o;
    int n_mismatch = 0;
    int samples_checked = 0;

    always #4 clk_i = ~clk_i;

    ccd_top DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .sync_i(sync_i),
        .route_block_i(route_block_i), .ch_clk_o(ch_clk_o),
        .ch_pd_o(ch_pd_o), .ch_dcc_en_o(ch_dcc_en_o));

    ccd_drv_model u_drv (.ch_clk_i(ch_clk_o[0]), .ch_pd_i(ch_pd_o[0]),
        .invert_i(invert_i), .out_o(drv_o));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [8:0] ra(input int ch, input int off);
        return `CCD_A_D0_CNT + 9'(3 * ch + off);
    endfunction

    task automatic reg_wr(input logic [8:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask

    task automatic reg_rd(input logic [8:0] a, output logic [7:0] d);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        @(negedge clk_i);
        d = reg_rdata_o;
    endtask

    // Fresh skips any partial run, so a count change mid-phase is not seen
    task automatic run_len(input int ch, input logic lv, input bit fresh,
                           output int n);
        int k;
        n = 0;
        for (k = 0; fresh && k < 64 && ch_clk_o[ch] === lv; k++)
            @(negedge clk_i);
        for (k = 0; fresh && k < 64 && ch_clk_o[ch] !== lv; k++)
            @(negedge clk_i);
        while (n < 64 && ch_clk_o[ch] === lv) begin
            n++;
            @(negedge clk_i);
        end
    endtask

    task automatic changes(input int ch, output int n);
        logic last;
        n = 0;
        last = ch_clk_o[ch];
        repeat (8) begin
            @(negedge clk_i);
            if (ch_clk_o[ch] !== last)
                n++;
            last = ch_clk_o[ch];
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] exp [6] = '{8'h77, 8'h00, 8'h00, 8'h33, 8'h00, 8'h00};
        logic [7:0] d;
        for (int i = 0; i < 6; i++) begin
            reg_rd(ra(0, i), d);
            check("reset value", exp[i], d);
        end
        check("pd after reset", 8'(ch_pd_o), 8'h00);
        check("dcc after reset", 8'(ch_dcc_en_o), 8'h03);
        // Write, then read on the very next edge: new value comes back
        reg_addr_i = ra(1, 0);
        reg_wdata_i = 8'h21;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b1;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        check("back to back", 8'h21, reg_rdata_o);
        reg_wr(ra(1, 0), 8'h33);
        reg_wr(9'h1E0, 8'h5A);
        reg_rd(9'h1E0, d);
        check("unmapped", 8'h00, d);
        reg_wr(ra(0, 2), 8'hFF);
        reg_rd(ra(0, 2), d);
        check("routing mask", 8'h07, d);
        reg_wr(ra(0, 2), 8'h00);
    endtask

    task automatic t_period(input int ch, input logic [7:0] cnt);
        int n;
        reg_wr(ra(ch, 0), cnt);
        run_len(ch, 1'b0, 1'b1, n);
        check("low run", 8'(cnt[7:4]) + 8'h01, 8'(n));
        run_len(ch, 1'b1, 1'b0, n);
        check("high run", 8'(cnt[3:0]) + 8'h01, 8'(n));
    endtask

    // Sync lands just after a fall, early in an eight-cycle low run
    task automatic t_sync(input int ch, input logic [7:0] ctl, input int exp);
        int k;
        int n;
        reg_wr(ra(ch, 0), 8'h71);
        reg_wr(ra(ch, 1), ctl);
        for (k = 0; k < 64 && ch_clk_o[ch] !== 1'b1; k++) @(negedge clk_i);
        for (k = 0; k < 64 && ch_clk_o[ch] !== 1'b0; k++) @(negedge clk_i);
        sync_i = 1'b1;
        @(negedge clk_i);
        sync_i = 1'b0;
        // One more edge: the channel flop shows the restart level now
        @(negedge clk_i);
        run_len(ch, ctl[4], 1'b0, n);
        check("start run after sync", 8'(exp), 8'(n));
    endtask

    task automatic t_force(input int ch);
        logic [7:0] ctl [4] = '{8'h70, 8'h60, 8'h80, 8'hF0};
        int exp [4] = '{0, 0, 8, 8};
        int n;
        reg_wr(ra(ch, 0), 8'h71);
        for (int i = 0; i < 4; i++) begin
            reg_wr(ra(ch, 1), ctl[i]);
            changes(ch, n);
            check("toggles", 8'(exp[i]), 8'(n));
            if (exp[i] == 0)
                check("forced level", 8'(ctl[i][4]), 8'(ch_clk_o[ch]));
        end
        if (ch == 0) begin
            invert_i = 1'b1;
            #1;
            check("inverted drive", 8'({3{~ch_clk_o[0]}}), 8'(drv_o));
            invert_i = 1'b0;
        end
        reg_wr(ra(ch, 1), 8'h30);
        run_len(ch, 1'b0, 1'b1, n);
        check("force without ignore", 8'h08, 8'(n));
        reg_wr(ra(ch, 1), 8'h00);
    endtask

    task automatic t_route(input int ch);
        int n;
        reg_wr(ra(ch, 2), 8'h04);
        changes(ch, n);
        check("pd toggles", 8'h00, 8'(n));
        check("pd flag", 8'(1 << ch), 8'(ch_pd_o));
        check("pd clock", 8'h00, 8'(ch_clk_o[ch]));
        if (ch == 0)
            check("safe drivers", 8'h00, 8'(drv_o));
        reg_wr(ra(ch, 2), 8'h02);
        changes(ch, n);
        check("direct", 8'h08, 8'(n));
        route_block_i = 1'b1;
        // Let the last direct toggle leave the output before measuring
        repeat (2) @(negedge clk_i);
        run_len(ch, 1'b0, 1'b1, n);
        check("direct blocked", 8'h08, 8'(n));
        route_block_i = 1'b0;
        reg_wr(ra(ch, 2), 8'h01);
        check("dcc off", 8'(2'h3 ^ (2'h1 << ch)), 8'(ch_dcc_en_o));
        reg_wr(ra(ch, 2), 8'h00);
        check("dcc on", 8'h03, 8'(ch_dcc_en_o));
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", samples_checked,
                 n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #200000;
        n_mismatch++;
        wrap_up();
    end

    initial begin
        repeat (12) @(negedge clk_i);
        rst_b_i = 1'b1;
        @(negedge clk_i);
        t_reset();
        t_period(0, 8'h77);
        t_period(0, 8'h25);
        t_period(1, 8'h0F);
        t_period(0, 8'h00);
        for (int ch = 0; ch < 2; ch++) begin
            t_sync(ch, 8'h10, 2);
            t_sync(ch, 8'h13, 5);
            t_sync(ch, 8'h1F, 17);
            t_sync(ch, 8'h00, 8);
            t_sync(ch, 8'h50, 0);
            t_force(ch);
            t_route(ch);
        end
        wrap_up();
    end
endmodule
